// ===== core/clk_switch_pkg.sv
// constants, register map and types for the cpu clock switchover block
package clk_switch_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W  = 3;

    localparam logic [ADDR_W-1:0] CPU_CTRL_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] MAIN_MODE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] OSC_MODE_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] INT_OSC_OFS   = 8'h0C;
    localparam logic [ADDR_W-1:0] HS_STOP_OFS   = 8'h10;

    // cpu_clock_ctrl_reg fields
    localparam int DIV_LSB        = 0;
    localparam int CPU_SUB_SEL_B  = 4;
    localparam int CPU_ON_SUB_B   = 5;
    localparam int SUB_START_B    = 6;
    // main_clock_mode_reg fields
    localparam int MAIN_SEL_B     = 0;
    localparam int MAIN_STATUS_B  = 1;
    localparam int HS_PERMIT_B    = 2;
    // osc_mode_select_reg fields
    localparam int HS_GAIN_B      = 0;
    localparam int SUB_MODE_B     = 4;
    localparam int SUB_EXT_B      = 5;
    localparam int HS_MODE_B      = 6;
    localparam int HS_EXT_B       = 7;
    // internal_osc_mode_reg fields
    localparam int INT_STOP_B     = 0;
    localparam int INT_STATUS_B   = 7;
    // main oscillator stop register field
    localparam int HS_STOP_B      = 7;

    localparam logic [DIV_W-1:0] DIV_RST     = 3'h0;
    localparam logic [DIV_W-1:0] DIV_MAX     = 3'h4;
    localparam logic             HS_STOP_RST = 1'b1;

    // switch delays in pre-switch cpu clocks, subsystem ticks and new main source ticks
    localparam logic [4:0] MAIN_DELAY_BASE = 5'h10;
    localparam logic [4:0] SUB_EXIT_CLKS   = 5'h02;
    localparam logic [1:0] SUB_WAIT_TICKS  = 2'h2;
    localparam logic [1:0] NEW_SRC_TICKS   = 2'h2;

    // gain raise withhold times
    localparam real CLK_PERIOD_NS   = 5.0;
    localparam real AMP_HOLD_MIN_US = 4.06;
    localparam real AMP_HOLD_MAX_US = 16.12;
    localparam int  AMP_HOLD_CYC    =
        int'($ceil(AMP_HOLD_MIN_US * 1000.0 / CLK_PERIOD_NS));
    localparam int  HOLD_W          = 10;
    localparam logic [HOLD_W-1:0] AMP_HOLD_CNT = HOLD_W'(AMP_HOLD_CYC);
    localparam logic [HOLD_W-1:0] EXT_HOLD_CNT = 10'h0A0;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_OLD,
        SW_SUB
    } swState_t;

endpackage : clk_switch_pkg

// ===== core/cpu_clock_switchover_control.sv
// cpu clock source selection, division and delayed switchover with apb
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cpu_clock_switchover_control (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic [clk_switch_pkg::ADDR_W-1:0]    paddr,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [clk_switch_pkg::DATA_W-1:0]    pwdata,
    output logic      [clk_switch_pkg::DATA_W-1:0]    prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic                                 intOscTick,
    input  wire logic                                 hsTick,
    input  wire logic                                 subTick,
    output logic                                      cpuTick,
    output logic                                      mainTick,
    output logic                                      cpuWithheld,
    output logic                                      intOscEn,
    output logic                                      hsXtalEn,
    output logic                                      hsExtEn,
    output logic                                      hsHighGain,
    output logic                                      subXtalEn,
    output logic                                      subExtEn,
    output logic                                      cpuOnSub,
    output logic                                      mainOnHs
);
    import clk_switch_pkg::*;

    // software control state
    logic [DIV_W-1:0]  cpuDivSel_q;
    logic              cpuSubSelect_q;
    logic              subOscStart_q;
    logic              mainSrcSelect_q;
    logic              hsSrcPermit_q;
    logic              hsPermitLocked_q;
    logic              hsExtInput_q;
    logic              hsOscMode_q;
    logic              hsAmpGain_q;
    logic              subExtInput_q;
    logic              subOscMode_q;
    logic              intOscStop_q;
    logic              hsSrcStop_q;
    // actual clocking state
    logic [DIV_W-1:0]  divAct_q;
    logic              onSub_q;
    logic              mainAct_q;
    swState_t          swState_q;
    logic [4:0]        swCnt_q;
    logic [1:0]        mainCnt_q;
    logic [3:0]        divCnt_q;
    logic [HOLD_W-1:0] holdCnt_q;
    logic              holdExt_q;
    logic [DATA_W-1:0] prdata_q;

    logic              wrEn;
    logic              setup;
    logic              mapped;
    logic              wrCpu;
    logic              wrMain;
    logic              wrOsc;
    logic              wrInt;
    logic              wrStop;
    logic [DIV_W-1:0]  divEff;
    logic [3:0]        divMask;
    logic              mainDivTick;
    logic              newSrcTick;
    logic              oldSrcTick;
    logic [DATA_W-1:0] rdVal;

    assign setup = psel && !penable;
    assign wrEn  = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        if (paddr == CPU_CTRL_OFS) begin
            mapped = 1'b1;
        end else if (paddr == MAIN_MODE_OFS) begin
            mapped = 1'b1;
        end else if (paddr == OSC_MODE_OFS) begin
            mapped = 1'b1;
        end else if (paddr == INT_OSC_OFS) begin
            mapped = 1'b1;
        end else if (paddr == HS_STOP_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign wrCpu  = wrEn && (paddr == CPU_CTRL_OFS);
    assign wrMain = wrEn && (paddr == MAIN_MODE_OFS);
    assign wrOsc  = wrEn && (paddr == OSC_MODE_OFS);
    assign wrInt  = wrEn && (paddr == INT_OSC_OFS);
    assign wrStop = wrEn && (paddr == HS_STOP_OFS);

    // zero wait state; read data captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    always_comb begin
        rdVal = '0;
        if (paddr == CPU_CTRL_OFS) begin
            rdVal[DIV_LSB +: DIV_W] = cpuDivSel_q;
            rdVal[CPU_SUB_SEL_B]    = cpuSubSelect_q;
            rdVal[CPU_ON_SUB_B]     = onSub_q;
            rdVal[SUB_START_B]      = subOscStart_q;
        end else if (paddr == MAIN_MODE_OFS) begin
            rdVal[MAIN_SEL_B]    = mainSrcSelect_q;
            rdVal[MAIN_STATUS_B] = mainAct_q;
            rdVal[HS_PERMIT_B]   = hsSrcPermit_q;
        end else if (paddr == OSC_MODE_OFS) begin
            rdVal[HS_GAIN_B]  = hsAmpGain_q;
            rdVal[SUB_MODE_B] = subOscMode_q;
            rdVal[SUB_EXT_B]  = subExtInput_q;
            rdVal[HS_MODE_B]  = hsOscMode_q;
            rdVal[HS_EXT_B]   = hsExtInput_q;
        end else if (paddr == INT_OSC_OFS) begin
            rdVal[INT_STOP_B]   = intOscStop_q;
            rdVal[INT_STATUS_B] = !intOscStop_q;
        end else if (paddr == HS_STOP_OFS) begin
            rdVal[HS_STOP_B] = hsSrcStop_q;
        end else begin
            rdVal = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= rdVal;
        end
    end

    // cpu clock control fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuDivSel_q    <= DIV_RST;
            cpuSubSelect_q <= 1'b0;
            subOscStart_q  <= 1'b0;
        end else if (wrCpu) begin
            cpuDivSel_q    <= pwdata[DIV_LSB +: DIV_W];
            cpuSubSelect_q <= pwdata[CPU_SUB_SEL_B];
            subOscStart_q  <= pwdata[SUB_START_B];
        end
    end

    // main clock mode; permit bit takes a single change per reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainSrcSelect_q  <= 1'b0;
            hsSrcPermit_q    <= 1'b0;
            hsPermitLocked_q <= 1'b0;
        end else if (wrMain) begin
            mainSrcSelect_q <= pwdata[MAIN_SEL_B];
            if (!hsPermitLocked_q &&
                (pwdata[HS_PERMIT_B] != hsSrcPermit_q)) begin
                hsSrcPermit_q    <= pwdata[HS_PERMIT_B];
                hsPermitLocked_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hsExtInput_q  <= 1'b0;
            hsOscMode_q   <= 1'b0;
            hsAmpGain_q   <= 1'b0;
            subExtInput_q <= 1'b0;
            subOscMode_q  <= 1'b0;
        end else if (wrOsc) begin
            hsExtInput_q  <= pwdata[HS_EXT_B];
            hsOscMode_q   <= pwdata[HS_MODE_B];
            hsAmpGain_q   <= pwdata[HS_GAIN_B];
            subExtInput_q <= pwdata[SUB_EXT_B];
            subOscMode_q  <= pwdata[SUB_MODE_B];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intOscStop_q <= 1'b0;
        end else if (wrInt) begin
            intOscStop_q <= pwdata[INT_STOP_B];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hsSrcStop_q <= HS_STOP_RST;
        end else if (wrStop) begin
            hsSrcStop_q <= pwdata[HS_STOP_B];
        end
    end

    // source enables follow the control bits directly
    assign intOscEn   = !intOscStop_q;
    assign hsXtalEn   = !hsSrcStop_q && hsOscMode_q && !hsExtInput_q;
    assign hsExtEn    = !hsSrcStop_q && hsOscMode_q && hsExtInput_q;
    assign hsHighGain = hsAmpGain_q;
    assign subXtalEn  = subOscStart_q || (subOscMode_q && !subExtInput_q);
    assign subExtEn   = !subOscStart_q && subExtInput_q && subOscMode_q;

    // main source switch: two new-source edges, then the next old edge
    assign newSrcTick = mainSrcSelect_q ? hsTick : intOscTick;
    assign oldSrcTick = mainAct_q ? hsTick : intOscTick;
    assign mainTick   = oldSrcTick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainAct_q <= 1'b0;
            mainCnt_q <= '0;
        end else if (mainSrcSelect_q != mainAct_q) begin
            if (mainCnt_q == NEW_SRC_TICKS) begin
                if (oldSrcTick) begin
                    mainAct_q <= mainSrcSelect_q;
                    mainCnt_q <= '0;
                end
            end else if (newSrcTick) begin
                mainCnt_q <= mainCnt_q + 2'h1;
            end
        end else begin
            mainCnt_q <= '0;
        end
    end

    // main clock division; codes above the largest act as the largest
    assign divEff  = (divAct_q > DIV_MAX) ? DIV_MAX : divAct_q;
    assign divMask = 4'((5'h01 << divEff) - 5'h01);
    assign mainDivTick = mainTick && ((divCnt_q & divMask) == 4'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= '0;
        end else if (mainTick) begin
            divCnt_q <= divCnt_q + 4'h1;
        end
    end

    // gain raise withholds the cpu clock while main runs on the high-speed oscillator and the cpu is not on subsystem
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            holdCnt_q <= '0;
            holdExt_q <= 1'b0;
        end else if (wrOsc && pwdata[HS_GAIN_B] && mainAct_q &&
                     hsOscMode_q && !onSub_q) begin
            holdExt_q <= hsExtInput_q;
            holdCnt_q <= hsExtInput_q ? EXT_HOLD_CNT
                                      : AMP_HOLD_CNT;
        end else if (holdCnt_q != '0 && (!holdExt_q || hsTick)) begin
            holdCnt_q <= holdCnt_q - HOLD_W'(1);
        end
    end

    assign cpuWithheld = (holdCnt_q != '0);
    assign cpuTick = !cpuWithheld && (onSub_q ? subTick : mainDivTick);

    // cpu clock switchover, counted in cpu clocks of the old setting, or in subsystem ticks when moving to the subsystem clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swState_q <= SW_IDLE;
            swCnt_q   <= '0;
            onSub_q   <= 1'b0;
            divAct_q  <= DIV_RST;
        end else if (wrCpu) begin
            if (pwdata[CPU_SUB_SEL_B] && !onSub_q) begin
                swState_q <= SW_SUB;
                swCnt_q   <= '0;
            end else begin
                swState_q <= SW_OLD;
                swCnt_q   <= onSub_q ? SUB_EXIT_CLKS
                                     : (MAIN_DELAY_BASE >> divEff);
            end
        end else begin
            case (swState_q)
                SW_OLD: begin
                    if (cpuTick) begin
                        if (swCnt_q <= 5'h01) begin
                            onSub_q   <= cpuSubSelect_q;
                            divAct_q  <= cpuDivSel_q;
                            swState_q <= SW_IDLE;
                        end else begin
                            swCnt_q <= swCnt_q - 5'h01;
                        end
                    end
                end
                SW_SUB: begin
                    // two subsystem periods, rounded up to an old cpu clock
                    if (swCnt_q[1:0] == SUB_WAIT_TICKS) begin
                        if (cpuTick) begin
                            onSub_q   <= cpuSubSelect_q;
                            divAct_q  <= cpuDivSel_q;
                            swState_q <= SW_IDLE;
                        end
                    end else if (subTick) begin
                        swCnt_q <= swCnt_q + 5'h01;
                    end
                end
                default: begin
                    swState_q <= SW_IDLE;
                end
            endcase
        end
    end

    assign cpuOnSub = onSub_q;
    assign mainOnHs = mainAct_q;

endmodule : cpu_clock_switchover_control

// ===== testbench/cpu_clock_switchover_control_asserts.sv
// port-level assertions for the cpu clock switchover block
`timescale 1ns/1ps
module cpu_clock_switchover_control_asserts
    import clk_switch_pkg::*;
(
    input wire logic                              clk,
    input wire logic                              rst_n,
    input wire logic [clk_switch_pkg::ADDR_W-1:0] paddr,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic                              intOscTick,
    input wire logic                              hsTick,
    input wire logic                              subTick,
    input wire logic                              cpuTick,
    input wire logic                              mainTick,
    input wire logic                              cpuWithheld,
    input wire logic                              hsXtalEn,
    input wire logic                              hsExtEn,
    input wire logic                              subXtalEn,
    input wire logic                              subExtEn,
    input wire logic                              cpuOnSub,
    input wire logic                              mainOnHs
);
    import clk_switch_pkg::*;

    logic        cpuWr;
    logic        mainWr;
    logic [11:0] heldCnt_q;

    assign cpuWr  = psel && penable && pwrite && (paddr == CPU_CTRL_OFS);
    assign mainWr = psel && penable && pwrite && (paddr == MAIN_MODE_OFS);

    // length of the current withhold in clk cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            heldCnt_q <= 12'h000;
        end else if (cpuWithheld) begin
            heldCnt_q <= heldCnt_q + 12'h001;
        end else begin
            heldCnt_q <= 12'h000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    main_tick_src_a: assert property (
        mainTick == (mainOnHs ? hsTick : intOscTick))
        else $error("main tick not from reported source");
    hold_gate_a: assert property (cpuWithheld |-> !cpuTick)
        else $error("cpu tick during withhold");
    hold_bound_a: assert property (
        cpuWithheld |-> heldCnt_q < 12'hC98)
        else $error("withhold longer than allowed");
    cpu_on_main_a: assert property (
        cpuTick && !cpuOnSub && !$changed(cpuOnSub) |-> mainTick)
        else $error("cpu tick without main tick");
    cpu_on_sub_a: assert property (
        cpuTick && cpuOnSub && !$changed(cpuOnSub) |-> subTick)
        else $error("cpu tick without subsystem tick");
    sub_delayed_a: assert property (
        $changed(cpuOnSub) |-> !$past(cpuWr))
        else $error("cpu source switched at once");
    main_delayed_a: assert property (
        $changed(mainOnHs) |-> !$past(mainWr))
        else $error("main source switched at once");
    hs_mode_excl_a: assert property (!(hsXtalEn && hsExtEn))
        else $error("both high-speed modes enabled");
    sub_mode_excl_a: assert property (!(subXtalEn && subExtEn))
        else $error("both subsystem modes enabled");
endmodule : cpu_clock_switchover_control_asserts

bind cpu_clock_switchover_control cpu_clock_switchover_control_asserts
    cpu_clock_switchover_control_asserts_i (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .intOscTick(intOscTick),
    .hsTick(hsTick), .subTick(subTick), .cpuTick(cpuTick),
    .mainTick(mainTick), .cpuWithheld(cpuWithheld), .hsXtalEn(hsXtalEn),
    .hsExtEn(hsExtEn), .subXtalEn(subXtalEn), .subExtEn(subExtEn),
    .cpuOnSub(cpuOnSub), .mainOnHs(mainOnHs));

// ===== testbench/cpu_clock_switchover_control_tb_top.sv
// self-checking bench for the cpu clock switchover block
`timescale 1ns/1ps
module cpu_clock_switchover_control_tb_top;
    import clk_switch_pkg::*;

    logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic              intOscTick, hsTick, subTick, cpuTick, mainTick, err;
    logic              cpuWithheld, intOscEn, hsXtalEn, hsExtEn, hsHighGain;
    logic              subXtalEn, subExtEn, cpuOnSub, mainOnHs;
    logic [31:0]       seed;
    int                fails, n_checks, n, h, c, m, k, e;

    cpu_clock_switchover_control cpu_clock_switchover_control_i (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .intOscTick(intOscTick), .hsTick(hsTick), .subTick(subTick),
        .cpuTick(cpuTick), .mainTick(mainTick), .cpuWithheld(cpuWithheld),
        .intOscEn(intOscEn), .hsXtalEn(hsXtalEn), .hsExtEn(hsExtEn),
        .hsHighGain(hsHighGain), .subXtalEn(subXtalEn),
        .subExtEn(subExtEn), .cpuOnSub(cpuOnSub), .mainOnHs(mainOnHs));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // random oscillator edges, subsystem much slower than the others
    always @(posedge clk) begin
        seed = xs(seed);
        intOscTick <= (seed[1:0] == 2'h0);
        hsTick     <= (seed[3:2] == 2'h0);
        subTick    <= (seed[7:4] == 4'h0);
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic chkRange(input string nm, input int lo, input int hi,
                            input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask : chkRange

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pready !== 1'b1 && c < 16);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'h1, 32'(pready));
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic rdChk(input string nm, input logic [ADDR_W-1:0] a,
                         input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rdChk

    // cycles and high-speed edges of one withhold, sampled after each edge
    task automatic measure();
        n = 0;
        h = 0;
        if (cpuWithheld !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        while (cpuWithheld === 1'b1 && n < 5000) begin
            if (hsTick === 1'b1) h++;
            n++;
            @(posedge clk);
            #1;
        end
    endtask : measure

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        seed = 32'hED2C6866;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        intOscTick = 1'b0;
        hsTick = 1'b0;
        subTick = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdChk("cpu ctrl rst", CPU_CTRL_OFS, 32'h0);
        rdChk("main mode rst", MAIN_MODE_OFS, 32'h0);
        rdChk("osc mode rst", OSC_MODE_OFS, 32'h0);
        rdChk("int osc rst", INT_OSC_OFS, 32'h80);
        rdChk("hs stop rst", HS_STOP_OFS, 32'h80);
        apb(1'b1, 8'h14, 32'hFF);
        chk("unmapped err", 32'h1, 32'(err));
        rdChk("unmapped data", 8'h14, 32'h0);
        apb(1'b1, OSC_MODE_OFS, 32'h30);
        chk("sub ext en", 32'h1, 32'(subExtEn));
        rdChk("osc mode", OSC_MODE_OFS, 32'h30);
        apb(1'b1, OSC_MODE_OFS, 32'h50);
        chk("sub xtal en", 32'h1, 32'(subXtalEn));
        apb(1'b1, HS_STOP_OFS, 32'h0);
        chk("hs xtal en", 32'h1, 32'(hsXtalEn));
        apb(1'b1, MAIN_MODE_OFS, 32'h4);
        apb(1'b1, MAIN_MODE_OFS, 32'h0);
        rdChk("permit once", MAIN_MODE_OFS, 32'h4);
        apb(1'b1, MAIN_MODE_OFS, 32'h5);
        chk("main early", 32'h0, 32'(mainOnHs));
        c = 0;
        while (mainOnHs !== 1'b1 && c < 500) begin
            @(posedge clk);
            #1;
            c++;
        end
        chkRange("main switch wait", 0, 499, c);
        rdChk("main status", MAIN_MODE_OFS, 32'h7);
        apb(1'b1, INT_OSC_OFS, 32'h1);
        chk("int osc en", 32'h0, 32'(intOscEn));
        rdChk("int osc stop", INT_OSC_OFS, 32'h1);
        apb(1'b1, INT_OSC_OFS, 32'h0);
        apb(1'b1, OSC_MODE_OFS, 32'h51);
        measure();
        chkRange("xtal hold", 812, 3224, n);
        apb(1'b1, OSC_MODE_OFS, 32'hD0);
        chk("hs ext en", 32'h1, 32'(hsExtEn));
        apb(1'b1, OSC_MODE_OFS, 32'hD1);
        measure();
        chkRange("ext hold ticks", 160, 161, h);
        // old code 0 keeps the old rate for 16 cpu clocks
        apb(1'b1, CPU_CTRL_OFS, 32'h4);
        k = 0;
        c = 0;
        while (c < 3000) begin
            @(posedge clk);
            #1;
            c++;
            if (mainTick === 1'b1 && cpuTick !== 1'b1) break;
            if (cpuTick === 1'b1) k++;
        end
        chkRange("switch delay", 16, 17, k);
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, CPU_CTRL_OFS, 32'(d));
            repeat (300) @(posedge clk);
            m = 0;
            k = 0;
            repeat (2000) begin
                @(posedge clk);
                #1;
                if (mainTick === 1'b1) m++;
                if (cpuTick === 1'b1) k++;
            end
            e = m >> (d > 4 ? 4 : d);
            chkRange("cpu div ratio", e - 1, e + 1, k);
        end
        apb(1'b1, CPU_CTRL_OFS, 32'h40);
        repeat (50) @(posedge clk);
        apb(1'b1, CPU_CTRL_OFS, 32'h50);
        chk("sub early", 32'h0, 32'(cpuOnSub));
        c = 0;
        while (cpuOnSub !== 1'b1 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        rdChk("on sub", CPU_CTRL_OFS, 32'h70);
        apb(1'b1, CPU_CTRL_OFS, 32'h43);
        chk("leave early", 32'h1, 32'(cpuOnSub));
        c = 0;
        while (cpuOnSub !== 1'b0 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        rdChk("back on main", CPU_CTRL_OFS, 32'h43);
        apb(1'b1, OSC_MODE_OFS, 32'hC0);
        chk("sub xtal kept", 32'h1, 32'(subXtalEn));
        chk("sub ext off", 32'h0, 32'(subExtEn));
        give_verdict();
    end
endmodule : cpu_clock_switchover_control_tb_top
